//--- ifec_pkg.sv
// Package of constants shared by the interrupt flag/enable controller and its core-side end.
// Function
// - Timer-F flags may re-set after clear in active mode.
// - Core waits validity interval before timer-F clear.
// - Core waits, reads timer-F status, then clears.
// - Longest instruction is 10 or 14 states.
// - Subactive mode clears timer-F flags without hazard.
// - Recommended: disable, wait, clear, read, re-enable.
// - Alternative: long handler, clear flags at end.
// - Same restrictions in 16-bit and 8-bit timer mode.
// - Edge select bits 1,0 read/write, reset zero.
// - Edge select bits 7 to 5 read one.
// - Enable one layout: bits 7,5,2,1,0 read/write.
// - Enable two layout: bits 7,6,3,2,0; reserved zero.
// - Request one flags 7,2,1,0; bit 5 reads one.
// - Request two flags 7,6,3,2,0; reserved zero.
package ifec_pkg;
    // Register indices on the device's own register port.
    localparam logic [2:0] ADDR_EDGE_SELECT = 3'h0;
    localparam logic [2:0] ADDR_ENABLE_ONE  = 3'h1;
    localparam logic [2:0] ADDR_ENABLE_TWO  = 3'h2;
    localparam logic [2:0] ADDR_REQUEST_ONE = 3'h3;
    localparam logic [2:0] ADDR_REQUEST_TWO = 3'h4;
    // Writable masks and forced-one read masks.
    localparam logic [7:0] EDGE_RW_MASK     = 8'h03;
    localparam logic [7:0] EDGE_READ_ONES   = 8'hE0;
    localparam logic [7:0] ONE_RW_MASK      = 8'hA7;
    localparam logic [7:0] EN_TWO_RW_MASK   = 8'hCD;
    localparam logic [7:0] REQ_ONE_FLAGS    = 8'h87;
    localparam logic [7:0] REQ_ONE_READ_ONE = 8'h20;
    localparam logic [7:0] REQ_TWO_FLAGS    = 8'hCD;
    // Source bit positions inside the request/enable registers.
    localparam int BIT_TIMER_A  = 7;
    localparam int BIT_WAKEUP   = 5;
    localparam int BIT_EC2      = 2;
    localparam int BIT_PIN1     = 1;
    localparam int BIT_PIN0     = 0;
    localparam int BIT_DT       = 7;
    localparam int BIT_ADC      = 6;
    localparam int BIT_TFH      = 3;
    localparam int BIT_TFL      = 2;
    localparam int BIT_EC       = 0;
    // Validity interval pieces for the core end.
    localparam int CLK_MHZ          = 200;
    localparam int SUBCLK_PERIOD_NS = 30518;
    localparam int STATES_PLAIN     = 10;
    localparam int STATES_MULDIV    = 14;
    localparam int SYNC_STATES      = 2;
    localparam int SUBCLK_CYCLES    = (SUBCLK_PERIOD_NS * CLK_MHZ + 999) / 1000;
    // Core APB register offsets.
    localparam logic [7:0] APB_CTRL    = 8'h00;
    localparam logic [7:0] APB_STATUS  = 8'h04;
    localparam logic [7:0] APB_IRQ_ST  = 8'h08;
    localparam logic [7:0] APB_IRQ_MSK = 8'h0C;
    localparam logic [7:0] APB_RDATA   = 8'h10;
    // Control bits of the core end.
    localparam int CTRL_START   = 0;
    localparam int CTRL_METHOD2 = 1;
    localparam int CTRL_MULDIV  = 2;
    localparam int CTRL_SUBACT  = 3;
    localparam int CTRL_READ    = 4;
    localparam int CTRL_ADDR_LO = 8;
    localparam int CTRL_WDATA_LO = 16;
endpackage : ifec_pkg

//--- ifec_if.sv
// Interface joining the interrupt controller and the processor-core end.
`timescale 1ns/1ps
interface ifec_if;
    logic       reg_sel;
    logic       reg_write;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic       irq_request;
    logic       subactive;
    logic       tf_status_read;

    modport device (input reg_sel, input reg_write, input reg_addr, input reg_wdata, input subactive,
                    input tf_status_read, output reg_rdata, output irq_request);
    modport core (output reg_sel, output reg_write, output reg_addr, output reg_wdata, output subactive,
                  output tf_status_read, input reg_rdata, input irq_request);
endinterface : ifec_if

//--- ifec_core.sv
// Processor-core end: runs the timer-F clear sequences and offers an APB register set.
`timescale 1ns/1ps
module ifec_core #(
    parameter int SUBCLK_CYCLES = ifec_pkg::SUBCLK_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    ifec_if.core             link,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000, ST_DIS = 3'b001, ST_WAIT = 3'b011, ST_CLR = 3'b010,
        ST_READ = 3'b110, ST_EN = 3'b111, ST_RAW = 3'b101
    } ifec_state_e;

    ifec_state_e  state;
    logic [31:0]  ctrl;
    logic [7:0]   rdata_hold;
    logic [1:0]   irq_st;
    logic [1:0]   irq_msk;
    logic [31:0]  wait_cnt;
    logic [31:0]  wait_len;
    logic [7:0]   saved_en;
    logic         wr;
    logic         req_edge;
    logic         req_q;

    assign wr      = psel && penable && pwrite;
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign irq     = |(irq_st & irq_msk);
    // In active mode the interval covers one subclock period, the longest instruction and two sync cycles; subactive mode waits one cycle.
    assign wait_len = link.subactive ? 32'h1 : 32'(SUBCLK_CYCLES)
        + (ctrl[ifec_pkg::CTRL_MULDIV] ? 32'(ifec_pkg::STATES_MULDIV) : 32'(ifec_pkg::STATES_PLAIN))
        + 32'(ifec_pkg::SYNC_STATES);

    // Software control word; start and read are self-clearing when the sequencer takes them.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl <= 32'h0;
        end else if (wr && paddr == ifec_pkg::APB_CTRL) begin
            ctrl <= pwdata;
        end else if (state == ST_IDLE) begin
            ctrl[ifec_pkg::CTRL_START] <= 1'b0;
            ctrl[ifec_pkg::CTRL_READ]  <= 1'b0;
        end
    end

    // Clear sequence, both timer widths alike; method 2 skips disable and re-enable.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state          <= ST_IDLE;
            wait_cnt       <= 32'h0;
            saved_en       <= 8'h00;
            rdata_hold     <= 8'h00;
            link.reg_sel   <= 1'b0;
            link.reg_write <= 1'b0;
            link.reg_addr  <= 3'h0;
            link.reg_wdata <= 8'h00;
            link.tf_status_read <= 1'b0;
        end else begin
            link.reg_sel        <= 1'b0;
            link.reg_write      <= 1'b0;
            link.tf_status_read <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (ctrl[ifec_pkg::CTRL_START]) begin
                        state         <= ST_DIS;
                        link.reg_sel  <= 1'b1;
                        link.reg_addr <= ifec_pkg::ADDR_ENABLE_TWO;
                    end else if (ctrl[ifec_pkg::CTRL_READ]) begin
                        state          <= ST_RAW;
                        link.reg_sel   <= 1'b1;
                        link.reg_write <= ctrl[ifec_pkg::CTRL_WDATA_LO + 8];
                        link.reg_addr  <= ctrl[ifec_pkg::CTRL_ADDR_LO +: 3];
                        link.reg_wdata <= ctrl[ifec_pkg::CTRL_WDATA_LO +: 8];
                    end
                end
                ST_RAW: begin
                    rdata_hold <= link.reg_rdata;
                    state      <= ST_IDLE;
                end
                ST_DIS: begin
                    saved_en <= link.reg_rdata;
                    wait_cnt <= 32'h0;
                    state    <= ST_WAIT;
                    if (!ctrl[ifec_pkg::CTRL_METHOD2]) begin
                        link.reg_sel   <= 1'b1;
                        link.reg_write <= 1'b1;
                        link.reg_addr  <= ifec_pkg::ADDR_ENABLE_TWO;
                        link.reg_wdata <= link.reg_rdata & ~8'h0C;
                    end
                end
                ST_WAIT: begin
                    wait_cnt <= wait_cnt + 32'h1;
                    if (wait_cnt + 32'h1 >= wait_len) begin
                        state          <= ST_CLR;
                        link.reg_sel   <= 1'b1;
                        link.reg_write <= 1'b1;
                        link.reg_addr  <= ifec_pkg::ADDR_REQUEST_TWO;
                        link.reg_wdata <= ifec_pkg::REQ_TWO_FLAGS & ~8'h0C;
                    end
                end
                ST_CLR: begin
                    // Status read precedes the overflow/compare clear in the timer.
                    link.tf_status_read <= 1'b1;
                    state               <= ST_READ;
                end
                ST_READ: begin
                    state <= ST_EN;
                end
                ST_EN: begin
                    // Enables come back only after the overflow/compare clear has been granted.
                    state <= ST_IDLE;
                    if (!ctrl[ifec_pkg::CTRL_METHOD2]) begin
                        link.reg_sel   <= 1'b1;
                        link.reg_write <= 1'b1;
                        link.reg_addr  <= ifec_pkg::ADDR_ENABLE_TWO;
                        link.reg_wdata <= saved_en & ifec_pkg::EN_TWO_RW_MASK;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Sticky events: sequence done and rising request from the device; set beats clear.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_st  <= 2'h0;
            irq_msk <= 2'h0;
            req_q   <= 1'b0;
        end else begin
            req_q <= link.irq_request;
            if (wr && paddr == ifec_pkg::APB_IRQ_MSK) begin
                irq_msk <= pwdata[1:0];
            end
            irq_st <= (wr && paddr == ifec_pkg::APB_IRQ_ST ? irq_st & ~pwdata[1:0] : irq_st)
                    | {req_edge, state == ST_EN};
        end
    end
    assign req_edge = link.irq_request && !req_q;

    // Subactive mode is a level taken from the control word.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            link.subactive <= 1'b0;
        end else begin
            link.subactive <= ctrl[ifec_pkg::CTRL_SUBACT];
        end
    end

    // APB read mux; unmapped addresses read zero.
    always_comb begin
        case (paddr)
            ifec_pkg::APB_CTRL:    prdata = ctrl;
            ifec_pkg::APB_STATUS:  prdata = {28'h0, link.irq_request, 3'(state)};
            ifec_pkg::APB_IRQ_ST:  prdata = {30'h0, irq_st};
            ifec_pkg::APB_IRQ_MSK: prdata = {30'h0, irq_msk};
            ifec_pkg::APB_RDATA:   prdata = {24'h0, rdata_hold};
            default:               prdata = 32'h0;
        endcase
    end
endmodule : ifec_core

//--- ifec_device.sv
// Device end: edge select, enable and request registers with request generation.
`timescale 1ns/1ps
module ifec_device (
    input  wire logic       clk,
    input  wire logic       rst_b,
    ifec_if.device          link,
    input  wire logic       pin0_level,
    input  wire logic       pin1_level,
    input  wire logic [7:0] src_one_event,
    input  wire logic [7:0] src_two_event,
    output logic            tf_flag_clear
);
    logic [1:0] edge_pol;
    logic [7:0] en_one;
    logic [7:0] en_two;
    logic [7:0] req_one;
    logic [7:0] req_two;
    logic [1:0] pin_q;
    logic [1:0] pin_hit;
    logic [7:0] set_one;
    logic [7:0] set_two;
    logic       wr;
    logic       status_seen;

    assign wr = link.reg_sel && link.reg_write;

    // Pin edge detection; polarity one selects rising edge.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_q <= 2'b00;
        end else begin
            pin_q <= {pin1_level, pin0_level};
        end
    end
    assign pin_hit = (edge_pol & {pin1_level, pin0_level} & ~pin_q)
                   | (~edge_pol & ~{pin1_level, pin0_level} & pin_q);
    assign set_one = (src_one_event | {6'h0, pin_hit}) & ifec_pkg::REQ_ONE_FLAGS;
    // A timer-F event still valid re-sets its flag right after a clear in active mode.
    assign set_two = src_two_event & ifec_pkg::REQ_TWO_FLAGS;

    // Edge select and enable registers; reserved enable bits hold zero, edge select stores only bits 1,0.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            edge_pol <= 2'b00;
            en_one   <= 8'h00;
            en_two   <= 8'h00;
        end else if (wr) begin
            case (link.reg_addr)
                ifec_pkg::ADDR_EDGE_SELECT: edge_pol <= link.reg_wdata[1:0];
                ifec_pkg::ADDR_ENABLE_ONE:  en_one   <= link.reg_wdata & ifec_pkg::ONE_RW_MASK;
                ifec_pkg::ADDR_ENABLE_TWO:  en_two   <= link.reg_wdata & ifec_pkg::EN_TWO_RW_MASK;
                default: ;
            endcase
        end
    end

    // Flags set by hardware regardless of enable; write zero clears, set wins.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            req_one <= 8'h00;
            req_two <= 8'h00;
        end else begin
            req_one <= ((wr && link.reg_addr == ifec_pkg::ADDR_REQUEST_ONE) ?
                        req_one & link.reg_wdata : req_one) | set_one;
            req_two <= ((wr && link.reg_addr == ifec_pkg::ADDR_REQUEST_TWO) ?
                        req_two & link.reg_wdata : req_two) | set_two;
        end
    end

    // Overflow/compare clear is passed to the timer after a status read, or in subactive mode on every cycle without one; any width.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            status_seen   <= 1'b0;
            tf_flag_clear <= 1'b0;
        end else begin
            tf_flag_clear <= 1'b0;
            if (link.tf_status_read) begin
                status_seen <= 1'b1;
            end else if (status_seen || link.subactive) begin
                tf_flag_clear <= 1'b1;
                status_seen   <= 1'b0;
            end
        end
    end

    // Read mux; reserved upper edge bits and request-one bit 5 read one.
    always_comb begin
        case (link.reg_addr)
            ifec_pkg::ADDR_EDGE_SELECT: link.reg_rdata = ifec_pkg::EDGE_READ_ONES | {6'h0, edge_pol};
            ifec_pkg::ADDR_ENABLE_ONE:  link.reg_rdata = en_one;
            ifec_pkg::ADDR_ENABLE_TWO:  link.reg_rdata = en_two;
            ifec_pkg::ADDR_REQUEST_ONE: link.reg_rdata = req_one | ifec_pkg::REQ_ONE_READ_ONE;
            ifec_pkg::ADDR_REQUEST_TWO: link.reg_rdata = req_two;
            default:                    link.reg_rdata = 8'h00;
        endcase
    end

    // Request to the core while any flag meets its enable.
    assign link.irq_request = |(req_one & en_one) | |(req_two & en_two);
endmodule : ifec_device

//--- ifec_chk.sv
// Checker of the link between the interrupt controller and the core end.
`timescale 1ns/1ps
module ifec_chk (
    input wire logic       clk,
    input wire logic       rst_b,
    input wire logic       reg_sel,
    input wire logic       reg_write,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic       irq_request,
    input wire logic       subactive,
    input wire logic       tf_status_read
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    // A write shows on the next read of the same register, through its writable mask.
    property p_wr(a, m, o);
        (reg_sel && reg_write && reg_addr == a) ##1 (reg_addr == a) |-> reg_rdata == (($past(reg_wdata) & m) | o);
    endproperty

    // Zeros written to request one clear those flags; set wins, so the bench keeps those sources quiet then.
    property p_clr;
        (reg_sel && reg_write && reg_addr == ifec_pkg::ADDR_REQUEST_ONE) ##1 (reg_addr == ifec_pkg::ADDR_REQUEST_ONE)
            |-> (reg_rdata & ~$past(reg_wdata) & ifec_pkg::REQ_ONE_FLAGS) == 8'h00;
    endproperty

    AST_EDGE_WR: assert property (p_wr(ifec_pkg::ADDR_EDGE_SELECT, ifec_pkg::EDGE_RW_MASK, ifec_pkg::EDGE_READ_ONES))
        else $error("edge select write mismatch");
    AST_EDGE_ONES: assert property (reg_addr == ifec_pkg::ADDR_EDGE_SELECT |-> reg_rdata[7:5] == 3'h7)
        else $error("edge ones lost");
    AST_EN1_WR: assert property (p_wr(ifec_pkg::ADDR_ENABLE_ONE, ifec_pkg::ONE_RW_MASK, 8'h00))
        else $error("enable one write mismatch");
    AST_EN2_WR: assert property (p_wr(ifec_pkg::ADDR_ENABLE_TWO, ifec_pkg::EN_TWO_RW_MASK, 8'h00))
        else $error("enable two write mismatch");
    AST_EN2_RES: assert property (reg_addr == ifec_pkg::ADDR_ENABLE_TWO |-> (reg_rdata & 8'h32) == 8'h00)
        else $error("enable two reserved");
    AST_REQ1_ONE: assert property (reg_addr == ifec_pkg::ADDR_REQUEST_ONE |-> reg_rdata[5])
        else $error("request one bit five low");
    AST_REQ2_RES: assert property (reg_addr == ifec_pkg::ADDR_REQUEST_TWO |-> (reg_rdata & 8'h32) == 8'h00)
        else $error("request two reserved");
    AST_REQ_CLR: assert property (p_clr)
        else $error("request one flag not cleared");

    // Main scenarios reached.
    CV_STATUS_READ: cover property (tf_status_read);
    CV_SUBACT_READ: cover property (subactive && tf_status_read);
    CV_IRQ_RISE: cover property ($rose(irq_request));
endmodule : ifec_chk

//--- interrupt_flag_enable_control_tb.sv
// Testbench joining both ends of the interrupt controller and driving the core end over APB.
`timescale 1ns/1ps
module interrupt_flag_enable_control_tb;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        irq;
    logic        pin0_level = 1'b0;
    logic        pin1_level = 1'b0;
    logic [7:0]  src_one_event = 8'h00;
    logic [7:0]  src_two_event = 8'h00;
    logic        tf_clr;
    int          tf_count = 0;
    int          mismatches = 0;
    int          check_count = 0;
    // A four-cycle subclock keeps the validity interval short in simulation.
    localparam int SIM_SUBCLK = 4;

    // Half-period toggle gives 200 MHz.
    always #2.5 clk = ~clk;

    // Count the permission pulses to clear timer-F status flags; one process owns the counter.
    always @(posedge clk) if (tf_clr === 1'b1) tf_count <= tf_count + 1;

    ifec_if link();
    ifec_device u_ifec_device (.clk(clk), .rst_b(rst_b), .link(link.device), .pin0_level(pin0_level),
        .pin1_level(pin1_level), .src_one_event(src_one_event), .src_two_event(src_two_event), .tf_flag_clear(tf_clr));
    ifec_core #(.SUBCLK_CYCLES(SIM_SUBCLK)) u_ifec_core (.clk(clk), .rst_b(rst_b), .link(link.core), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(), .irq(irq));
    ifec_chk chk (.clk(clk), .rst_b(rst_b), .reg_sel(link.reg_sel), .reg_write(link.reg_write),
        .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata), .reg_rdata(link.reg_rdata),
        .irq_request(link.irq_request), .subactive(link.subactive), .tf_status_read(link.tf_status_read));

    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : conclude

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    // One APB transfer; request held until pready is sampled high at a rising edge.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clk);
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
        q = prdata;
        psel <= 1'b0; penable <= 1'b0;
        if (n >= 50) begin mismatches++; conclude(); end
    endtask : apb

    // Device register access through the core, waiting for the core to go idle.
    task automatic raw(input logic wr, input logic [2:0] a, input logic [7:0] d, output logic [7:0] q);
        logic [31:0] r;
        int n;
        apb(1'b1, 8'h00, {7'h00, wr, d, 5'h00, a, 8'h10}, r);
        n = 0;
        do begin apb(1'b0, 8'h04, 32'h0, r); n++; end while (r[2:0] !== 3'h0 && n < 20);
        if (n >= 20) begin mismatches++; conclude(); end
        apb(1'b0, 8'h10, 32'h0, r);
        q = r[7:0];
    endtask : raw

    task automatic t_reset;
        logic [7:0] q;
        logic [7:0] e [5] = '{8'hE0, 8'h00, 8'h00, 8'h20, 8'h00};
        for (int i = 0; i < 5; i++) begin raw(1'b0, 3'(i), 8'h00, q); check("reset", e[i], q); end
    endtask : t_reset

    // All ones written; reserved and flag bits must not follow.
    task automatic t_reserved;
        logic [7:0] q;
        logic [7:0] e [5] = '{8'hE3, 8'hA7, 8'hCD, 8'h20, 8'h00};
        for (int i = 0; i < 5; i++) begin
            raw(1'b1, 3'(i), 8'hFF, q);
            raw(1'b0, 3'(i), 8'h00, q);
            check("all ones", e[i], q);
        end
        for (int i = 0; i < 3; i++) raw(1'b1, 3'(i), 8'h00, q);
    endtask : t_reserved

    // Events set flags regardless of enable; zero clears, one keeps.
    task automatic t_events;
        logic [7:0] q;
        @(posedge clk); src_one_event <= 8'hFF; src_two_event <= 8'hFF;
        @(posedge clk); src_one_event <= 8'h00; src_two_event <= 8'h00;
        raw(1'b0, 3'h3, 8'h00, q); check("req one set", 8'hA7, q);
        raw(1'b0, 3'h4, 8'h00, q); check("req two set", 8'hCD, q);
        raw(1'b1, 3'h3, 8'h00, q); raw(1'b0, 3'h3, 8'h00, q); check("req one clr", 8'h20, q);
        raw(1'b1, 3'h4, 8'h0C, q); raw(1'b0, 3'h4, 8'h00, q); check("req two keep", 8'h0C, q);
    endtask : t_events

    // Pin zero senses rising edges, pin one falling edges.
    task automatic t_edges;
        logic [7:0] q;
        raw(1'b1, 3'h0, 8'h01, q);
        @(posedge clk); pin0_level <= 1'b1; pin1_level <= 1'b1;
        raw(1'b0, 3'h3, 8'h00, q); check("rise", 8'h21, q);
        @(posedge clk); pin0_level <= 1'b0; pin1_level <= 1'b0;
        raw(1'b0, 3'h3, 8'h00, q); check("fall", 8'h23, q);
        raw(1'b1, 3'h3, 8'h00, q);
    endtask : t_edges

    // Enabling pending timer-F flags raises the request; the sticky rise bit is masked and cleared.
    task automatic t_irq;
        logic [31:0] r;
        logic [7:0]  q;
        apb(1'b1, 8'h0C, 32'h2, r);
        raw(1'b1, 3'h2, 8'h0C, q);
        apb(1'b0, 8'h04, 32'h0, r); check("request", 32'h1, 32'(r[3]));
        check("irq on", 32'h1, 32'(irq));
        apb(1'b1, 8'h08, 32'h2, r); @(posedge clk); check("irq off", 32'h0, 32'(irq));
    endtask : t_irq

    // Clear sequences: method one, method two, long instructions, subactive.
    // The timer-F source stays valid for a whole validity interval, so a clear that comes too early is undone.
    task automatic t_seq;
        logic [31:0] r;
        logic [7:0]  q;
        logic [31:0] mode [4] = '{32'h1, 32'h3, 32'h5, 32'h9};
        int          n;
        int          hold;
        int          base;
        foreach (mode[i]) begin
            hold = mode[i][ifec_pkg::CTRL_SUBACT] ? 1 : SIM_SUBCLK + ifec_pkg::SYNC_STATES
                 + (mode[i][ifec_pkg::CTRL_MULDIV] ? ifec_pkg::STATES_MULDIV : ifec_pkg::STATES_PLAIN);
            base = tf_count;
            apb(1'b1, 8'h00, mode[i], r);
            src_two_event <= 8'h0C;
            repeat (hold) @(posedge clk);
            src_two_event <= 8'h00;
            n = 0;
            do begin apb(1'b0, 8'h08, 32'h0, r); n++; end while (r[0] !== 1'b1 && n < 300);
            if (n >= 300) begin mismatches++; conclude(); end
            raw(1'b0, 3'h4, 8'h00, q); check("tf cleared", 8'h00, q);
            raw(1'b0, 3'h2, 8'h00, q); check("re-enabled", 8'h0C, q);
            check("flag clear", 32'h1, mode[i][ifec_pkg::CTRL_SUBACT] ? 32'(tf_count != base) : 32'(tf_count - base));
            apb(1'b1, 8'h08, 32'h3, r); @(posedge clk); check("irq idle", 32'h0, 32'(irq));
        end
    endtask : t_seq

    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_reserved();
        t_events();
        t_edges();
        t_irq();
        t_seq();
        conclude();
    end
endmodule : interrupt_flag_enable_control_tb
